// >>> bench/eppc_periph_model.sv
// behavioural epp peripheral that answers strobes through its wait line
module eppc_periph_model (
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // epp lines from the port
   input wire logic data_strobe_n,
   input wire logic address_strobe_alt_n,
   input wire logic [eppc_pkg::EPPC_DATA_W-1:0] peripheral_data_pins_out,
   input wire logic peripheral_data_pins_oe,
   output logic [eppc_pkg::EPPC_DATA_W-1:0] peripheral_data_pins_in,
   output logic wait_n,
   // bench controls and observation
   input wire logic stall,
   input wire logic [7:0] dly,
   output logic [7:0] seen_byte
);
   timeunit 1ns;
   timeprecision 1ps;
   import eppc_pkg::*;
   logic [7:0] cnt;
   logic [7:0] last;
   logic drv;
   logic is_addr;
   always_ff @(posedge clock) begin
      last <= peripheral_data_pins_in;
      if (!rst_b) begin
         cnt <= 8'h00;
         wait_n <= 1'b0;
         seen_byte <= 8'h00;
         drv <= 1'b0;
         is_addr <= 1'b0;
      end else if (!data_strobe_n || !address_strobe_alt_n) begin
         is_addr <= !address_strobe_alt_n;
         drv <= !peripheral_data_pins_oe;
         cnt <= cnt + 8'h01;
         // data is up at least two cycles before wait rises, as dly is 3 or more
         if (cnt >= dly && !stall) begin
            wait_n <= 1'b1;
         end
         if (peripheral_data_pins_oe) begin
            seen_byte <= peripheral_data_pins_out;
         end
      end else begin
         cnt <= 8'h00;
         wait_n <= 1'b0;
         drv <= 1'b0;
      end
   end
   // released pins show a changing pattern outside a strobe, and a held byte while a read strobe is low
   always_comb begin
      if (peripheral_data_pins_oe) begin
         peripheral_data_pins_in = peripheral_data_pins_out;
      end else if (drv) begin
         peripheral_data_pins_in = seen_byte ^ (is_addr ? 8'hf0 : 8'h3c);
      end else begin
         peripheral_data_pins_in = ~last;
      end
   end
endmodule // eppc_periph_model

// >>> bench/eppc_port_monitor.sv
// concurrent checks on the epp port pins and register bus
module eppc_port_monitor #(
   parameter int WDOG_CYC = 20
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // watched ports
   input wire logic avs_waitrequest,
   input wire logic [eppc_pkg::EPPC_DATA_W-1:0] peripheral_data_pins_out,
   input wire logic peripheral_data_pins_oe,
   input wire logic write_n,
   input wire logic data_strobe_n,
   input wire logic address_strobe_alt_n,
   input wire logic direction_output,
   input wire logic strobe_n,
   input wire logic wait_n,
   input wire logic intr,
   input wire logic intr_out
);
   timeunit 1ns;
   timeprecision 1ps;
   import eppc_pkg::*;
   // ------------------------------------------------------------
   // run counters: strobe length and how long wait has been low
   // ------------------------------------------------------------
   logic strb_on;
   logic [15:0] st_run_ff;
   logic [3:0] wl_run_ff;
   assign strb_on = !data_strobe_n || !address_strobe_alt_n;
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         st_run_ff <= 16'h0000;
         wl_run_ff <= 4'h0;
      end else begin
         st_run_ff <= strb_on ? st_run_ff + 16'h0001 : 16'h0000;
         // saturate so a long stall does not wrap back to a short one
         wl_run_ff <= wait_n ? 4'h0 : ((wl_run_ff == 4'hf) ? wl_run_ff : wl_run_ff + 4'h1);
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   a_strobes_apart: assert property (data_strobe_n || address_strobe_alt_n)
      else $error("both epp strobes low");
   a_answer_idle: assert property (!avs_waitrequest |->
      data_strobe_n && address_strobe_alt_n)
      else $error("answer given while a strobe is low");
   a_oe_by_dir: assert property (peripheral_data_pins_oe != direction_output)
      else $error("pin drive disagrees with direction");
   // the write line leaves reset released and settles one cycle later
   a_write_link: assert property ($past(rst_b) |->
      write_n == (direction_output && strobe_n))
      else $error("write line not set by direction and spp strobe");
   a_intr_pass: assert property (intr_out == $past(intr, 3))
      else $error("interrupt not passed through");
   a_pins_held: assert property ((strb_on || $rose(data_strobe_n) ||
      $rose(address_strobe_alt_n)) && peripheral_data_pins_oe |->
      $stable(peripheral_data_pins_out))
      else $error("pin byte moved around a write strobe");
   a_wait_stalls: assert property (strb_on ##1 (!strb_on && wl_run_ff > 4'h7)
      |-> st_run_ff >= WDOG_CYC - 2)
      else $error("cycle ended while wait low before timeout");
   a_wdog_bound: assert property (strb_on |-> st_run_ff < WDOG_CYC + 8)
      else $error("strobe outlived the watchdog");
   // wait crosses two sync flops, so the strobe is seen dropped on the fourth sample
   a_quick_end: assert property ((strb_on && wait_n) [*3] |-> ##1 !strb_on)
      else $error("cycle not ended after wait released");
   c_addr_cycle: cover property (!address_strobe_alt_n);
   c_read_cycle: cover property (!data_strobe_n && direction_output);
   c_timeout: cover property (strb_on && st_run_ff >= WDOG_CYC - 2);
endmodule // eppc_port_monitor

bind eppc_port eppc_port_monitor #(.WDOG_CYC(WDOG_CYC)) eppc_port_monitor_inst (.*);

// >>> bench/test_eppc_port.sv
// self-checking bench of the epp port against a behavioural peripheral
`define CHK(nm, ex, gt) begin \
   cmp_count++; \
   if ((gt) !== (ex)) begin \
      err_total++; \
      $display("CHECK FAILED %s exp %h got %h", nm, ex, gt); \
   end \
end
module test_eppc_port;
   timeunit 1ns;
   timeprecision 1ps;
   import eppc_pkg::*;
   localparam int WDOG = 20;
   typedef struct packed {
      logic [3:0] op;
      logic [3:0] idx;
      logic [7:0] wd;
      logic [3:0] kind;
      logic [7:0] ex;
   } eppc_row_t;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic [EPPC_ADDR_W-1:0] avs_address = 6'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [3:0] avs_byteenable = 4'h1;
   logic [EPPC_BUS_W-1:0] avs_writedata = 32'h0, avs_readdata;
   logic avs_waitrequest, peripheral_data_pins_oe, write_n, data_strobe_n;
   logic [7:0] peripheral_data_pins_in, peripheral_data_pins_out, seen_byte, got;
   logic address_strobe_alt_n, direction_output, strobe_n, autofeed_n;
   logic periph_reset_n, select_in_n, wait_n, intr_out;
   logic intr = 1'b0, paper_end = 1'b1, selected = 1'b0, error_n = 1'b1, stall = 1'b0;
   logic [7:0] dly = 8'h03;
   logic [31:0] rd;
   logic [14:0] rst_vec;
   assign rst_vec = {avs_waitrequest, peripheral_data_pins_oe, write_n, data_strobe_n,
                     address_strobe_alt_n, direction_output, periph_reset_n,
                     peripheral_data_pins_out};
   int err_total = 0, cmp_count = 0, waited;
   eppc_row_t r;
   eppc_row_t rows [17] = '{
      28'h1_8_01_0_00, 28'h1_2_00_4_34,
      28'h1_3_5a_2_5a, 28'h1_4_c3_2_c3, 28'h1_7_81_3_81, 28'h0_2_00_1_00,
      28'h1_2_20_4_37, 28'h0_4_00_1_bd, 28'h0_3_00_1_71, 28'h0_6_00_1_bd,
      28'h1_2_21_4_16, 28'h0_1_00_1_28, 28'h1_2_0f_4_08, 28'h1_0_a7_3_a7,
      28'h1_8_00_0_00, 28'h0_4_00_1_00, 28'h1_3_ee_2_81};
   eppc_port #(.WDOG_CYC(WDOG)) eppc_port_inst (.*);
   eppc_periph_model eppc_periph_model_inst (.*);
   initial begin
      forever #2 clock = ~clock;
   end
   // ------------------------------------------------------------
   // bus and report tasks
   // ------------------------------------------------------------
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // avalon master: holds the request until waitrequest is seen low
   task automatic bus(input logic wr, input logic [3:0] idx, input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge clock);
      avs_address <= {idx, 2'b00};
      avs_writedata <= {24'h000000, wd};
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge clock);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 5000);
      waited = n;
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (n >= 5000) begin
         err_total++;
         conclude();
      end
   endtask
   task automatic chk_rst();
      `CHK("reset outs", 15'h7c00, rst_vec)
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clock);
      chk_rst();
      rst_b <= 1'b1;
      foreach (rows[i]) begin
         r = rows[i];
         bus(r.op[0], r.idx, r.wd);
         repeat (2) @(posedge clock);
         case (r.kind)
            4'h1: got = rd[7:0];
            4'h2: got = seen_byte;
            4'h3: got = peripheral_data_pins_out;
            default: got = {2'b00, strobe_n, autofeed_n, periph_reset_n, select_in_n,
                            direction_output, write_n};
         endcase
         if (r.kind != 4'h0) begin
            `CHK("row", r.ex, got)
         end
         $display("row %0d done", i);
      end
      bus(1'b1, 4'h8, 8'h01);
      bus(1'b1, 4'h2, 8'h00);
      dly <= 8'h0c;
      bus(1'b1, 4'h5, 8'h69);
      `CHK("slow stretch", 1'b1, (waited >= 12))
      `CHK("slow byte", 8'h69, seen_byte)
      $display("slow peripheral done");
      stall <= 1'b1;
      intr <= 1'b1;
      bus(1'b1, 4'h6, 8'h3e);
      `CHK("timeout stretch", 1'b1, (waited >= WDOG))
      stall <= 1'b0;
      bus(1'b0, 4'h1, 8'h00);
      `CHK("timeout flag", 8'h69, rd[7:0])
      bus(1'b1, 4'h1, 8'h01);
      bus(1'b0, 4'h1, 8'h00);
      `CHK("flag cleared", 8'h68, rd[7:0])
      intr <= 1'b0;
      $display("timeout done");
      bus(1'b1, 4'h2, 8'h0f);
      // a write with the low byte lane off must leave the control byte alone
      avs_byteenable <= 4'h0;
      bus(1'b1, 4'h2, 8'h3f);
      avs_byteenable <= 4'h1;
      bus(1'b0, 4'h2, 8'h00);
      `CHK("masked write", 8'h0f, rd[7:0])
      $display("masked write done");
      repeat (4) @(posedge clock);
      rst_b <= 1'b0;
      repeat (10) @(posedge clock);
      chk_rst();
      rst_b <= 1'b1;
      bus(1'b0, 4'h4, 8'h00);
      `CHK("epp off after reset", 8'h00, rd[7:0])
      // a refused index is answered like a plain register, with no strobe cycle
      `CHK("refused at once", 1'b1, (waited == 2))
      $display("mid-run reset done");
      conclude();
   end
endmodule // test_eppc_port

// >>> hdl/eppc_pkg.sv
// shared constants, register map and state encoding of the epp 1.7 port
package eppc_pkg;

   // ----------------------------------------------------------------
   // bus geometry
   // ----------------------------------------------------------------
   localparam int EPPC_ADDR_W = 6;
   localparam int EPPC_DATA_W = 8;
   localparam int EPPC_BUS_W = 32;

   // ----------------------------------------------------------------
   // register indices, byte address is four times the index
   // ----------------------------------------------------------------
   localparam logic [3:0] EPPC_IDX_SPP_DATA = 4'h0;
   localparam logic [3:0] EPPC_IDX_STATUS = 4'h1;
   localparam logic [3:0] EPPC_IDX_CONTROL = 4'h2;
   localparam logic [3:0] EPPC_IDX_EPP_ADDR = 4'h3;
   localparam logic [3:0] EPPC_IDX_EPP_DATA0 = 4'h4;
   localparam logic [3:0] EPPC_IDX_EPP_DATA3 = 4'h7;
   localparam logic [3:0] EPPC_IDX_CONFIG = 4'h8;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int EPPC_CTL_STROBE = 0;
   localparam int EPPC_CTL_AUTOFD = 1;
   localparam int EPPC_CTL_INIT = 2;
   localparam int EPPC_CTL_SELIN = 3;
   localparam int EPPC_CTL_IRQE = 4;
   localparam int EPPC_CTL_DIR = 5;
   localparam int EPPC_CTL_W = 6;
   localparam int EPPC_STS_TIMEOUT = 0;
   localparam int EPPC_STS_ERR = 3;
   localparam int EPPC_STS_SLCT = 4;
   localparam int EPPC_STS_PE = 5;
   localparam int EPPC_STS_INTR = 6;
   localparam int EPPC_STS_WAIT = 7;
   localparam int EPPC_CFG_EPP_EN = 0;

   // ----------------------------------------------------------------
   // synchronised input lanes
   // ----------------------------------------------------------------
   localparam int EPPC_SY_WAIT = 0;
   localparam int EPPC_SY_INTR = 1;
   localparam int EPPC_SY_PE = 2;
   localparam int EPPC_SY_SLCT = 3;
   localparam int EPPC_SY_ERR = 4;
   localparam int EPPC_SY_W = 5;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [EPPC_CTL_W-1:0] EPPC_CTL_RST = 6'h00;
   localparam logic [EPPC_DATA_W-1:0] EPPC_BYTE_RST = 8'h00;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int EPPC_CLK_MHZ = 250;
   localparam int EPPC_WDOG_NS = 10000;
   // longest time, rounded down
   localparam int EPPC_WDOG_CYC = (EPPC_WDOG_NS * EPPC_CLK_MHZ) / 1000;
   localparam int EPPC_WDOG_W = 13;

   // ----------------------------------------------------------------
   // cycle states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      EPPC_IDLE = 2'b00,
      EPPC_ANSWER = 2'b01,
      EPPC_SETUP = 2'b10,
      EPPC_STROBE = 2'b11
   } eppc_state_t;

endpackage

// >>> hdl/eppc_port.sv
// epp 1.7 parallel port cycle engine with spp fallback and avalon-mm registers

// What this block does
// RQ1: outside EPP cycles, data pins and strobe/autofeed/init follow SPP control
// RQ2: watchdog aborts any EPP cycle beyond 10 us and sets status bit 0
// RQ3: software clears control D0, D1, D3 and sets D5 per direction first
// RQ4: hold the bus cycle while peripheral wait is low; finish once high
// RQ5: wait asserted keeps bus stalled until wait released or timeout
// RQ6: software clears direction bit, then writes an EPP register
// RQ7: EPP write places byte on pins, then asserts data or address strobe
// RQ8: at write end strobe drops and the byte stays latched on pins
// RQ9: direction bit set releases write and tri-states pins; strobe on read
// RQ10: peripheral drives data then raises wait during EPP read
// RQ11: at read end strobe drops; peripheral then releases pins
// RQ12: write, data strobe, address strobe and peripheral reset are active low
// RQ13: peripheral raises wait to acknowledge, lowers it when ready again
// RQ14: interrupt input passes through unchanged, active high
// RQ15: direction output low unless direction bit set or EPP read running
// RQ16: only write line is overridden by SPP control; registers are shared
// RQ17: EPP address register at index 3, reset cleared, EPP mode only
// RQ18: EPP data registers at indices 4 to 7, data strobe, EPP mode only
// RQ19: watchdog counts system clocks up to the 10 us limit
// RQ20: wait and interrupt pass a two-flop synchroniser before use
module eppc_port #(
   parameter int WDOG_CYC = eppc_pkg::EPPC_WDOG_CYC
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // avalon-mm register slave
   input wire logic [eppc_pkg::EPPC_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic [eppc_pkg::EPPC_BUS_W-1:0] avs_writedata,
   output logic [eppc_pkg::EPPC_BUS_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   // peripheral data pins
   input wire logic [eppc_pkg::EPPC_DATA_W-1:0] peripheral_data_pins_in,
   output logic [eppc_pkg::EPPC_DATA_W-1:0] peripheral_data_pins_out,
   output logic peripheral_data_pins_oe,
   // peripheral control outputs
   output logic write_n,
   output logic data_strobe_n,
   output logic address_strobe_alt_n,
   output logic direction_output,
   output logic strobe_n,
   output logic autofeed_n,
   output logic periph_reset_n,
   output logic select_in_n,
   // peripheral inputs
   input wire logic wait_n,
   input wire logic intr,
   input wire logic paper_end,
   input wire logic selected,
   input wire logic error_n,
   // interrupt pass-through
   output logic intr_out
);
   import eppc_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      eppc_state_t state;
      logic waitrequest;
      logic [EPPC_BUS_W-1:0] readdata;
      logic [EPPC_DATA_W-1:0] spp_data;
      logic [EPPC_CTL_W-1:0] ctrl;
      logic epp_en;
      logic timeout;
      logic [EPPC_DATA_W-1:0] epp_addr;
      logic [EPPC_DATA_W-1:0] epp_data;
      logic cyc_read;
      logic cyc_addr;
      logic cyc_host_rd;
      logic [EPPC_DATA_W-1:0] pd_out;
      logic pd_oe;
      logic dir_out;
      logic write_n;
      logic data_strobe_n;
      logic addr_strobe_n;
      logic strobe_n;
      logic autofd_n;
      logic init_n;
      logic select_in_n;
      logic intr_out;
   } eppc_port_st_t;

   eppc_port_st_t st_ff;
   eppc_port_st_t nxt_st;

   logic [EPPC_SY_W-1:0] sy_in;
   logic [EPPC_SY_W-1:0] sy_out;
   logic [EPPC_DATA_W-1:0] pd_sync;
   logic wd_run;
   logic wd_expired;
   logic [3:0] idx;
   logic wait_hi;

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   assign sy_in = {error_n, selected, paper_end, intr, wait_n};

   eppc_sync #(.W(EPPC_SY_W)) u_sync_ctl ( // RQ20
      .clock(clock),
      .rst_b(rst_b),
      .d_async(sy_in),
      .q_sync(sy_out)
   );

   eppc_sync #(.W(EPPC_DATA_W)) u_sync_pd (
      .clock(clock),
      .rst_b(rst_b),
      .d_async(peripheral_data_pins_in),
      .q_sync(pd_sync)
   );

   // ----------------------------------------------------------------
   // watchdog
   // ----------------------------------------------------------------
   // runs from the strobe setup until the bus cycle is answered
   assign wd_run = (st_ff.state == EPPC_SETUP) || (st_ff.state == EPPC_STROBE); // RQ2

   eppc_wdog #(.LIMIT(WDOG_CYC), .CW(EPPC_WDOG_W)) u_wdog (
      .clock(clock),
      .rst_b(rst_b),
      .run(wd_run),
      .expired(wd_expired)
   );

   assign idx = avs_address[EPPC_ADDR_W-1:2];
   assign wait_hi = sy_out[EPPC_SY_WAIT];

   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   function automatic logic is_epp_idx(input logic [3:0] i);
      return (i >= EPPC_IDX_EPP_ADDR) && (i <= EPPC_IDX_EPP_DATA3); // RQ17 RQ18
   endfunction

   function automatic logic [EPPC_DATA_W-1:0] status_byte(input eppc_port_st_t s,
                                                          input logic [EPPC_SY_W-1:0] y);
      logic [EPPC_DATA_W-1:0] b;
      b = '0;
      b[EPPC_STS_TIMEOUT] = s.timeout;
      b[EPPC_STS_ERR] = y[EPPC_SY_ERR];
      b[EPPC_STS_SLCT] = y[EPPC_SY_SLCT];
      b[EPPC_STS_PE] = y[EPPC_SY_PE];
      b[EPPC_STS_INTR] = y[EPPC_SY_INTR];
      b[EPPC_STS_WAIT] = y[EPPC_SY_WAIT];
      return b;
   endfunction

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      nxt_st.waitrequest = 1'b1;
      unique case (st_ff.state)
         EPPC_IDLE: begin
            // a request is taken only while waitrequest stands high, so the
            // request answered in the previous cycle is never taken twice
            if ((avs_read || avs_write) && st_ff.waitrequest) begin
               nxt_st.readdata = '0;
               if (is_epp_idx(idx) && st_ff.epp_en) begin
                  // pin direction follows the direction bit, so a write
                  // with the bit set runs as a read on the pins
                  nxt_st.cyc_read = st_ff.ctrl[EPPC_CTL_DIR]; // RQ9
                  nxt_st.cyc_addr = (idx == EPPC_IDX_EPP_ADDR);
                  nxt_st.cyc_host_rd = avs_read;
                  if (!st_ff.ctrl[EPPC_CTL_DIR]) begin
                     nxt_st.pd_out = avs_writedata[EPPC_DATA_W-1:0]; // RQ7
                  end
                  nxt_st.state = EPPC_SETUP;
               end else begin
                  nxt_st.waitrequest = 1'b0;
                  nxt_st.state = EPPC_ANSWER;
                  if (avs_read) begin
                     if (idx == EPPC_IDX_SPP_DATA) begin
                        nxt_st.readdata[EPPC_DATA_W-1:0] =
                           st_ff.ctrl[EPPC_CTL_DIR] ? pd_sync : st_ff.spp_data;
                     end else if (idx == EPPC_IDX_STATUS) begin
                        nxt_st.readdata[EPPC_DATA_W-1:0] = status_byte(st_ff, sy_out);
                     end else if (idx == EPPC_IDX_CONTROL) begin
                        nxt_st.readdata[EPPC_CTL_W-1:0] = st_ff.ctrl;
                     end else if (idx == EPPC_IDX_CONFIG) begin
                        nxt_st.readdata[EPPC_CFG_EPP_EN] = st_ff.epp_en;
                     end
                  end else if (avs_byteenable[0]) begin
                     if (idx == EPPC_IDX_SPP_DATA) begin
                        nxt_st.spp_data = avs_writedata[EPPC_DATA_W-1:0];
                        nxt_st.pd_out = avs_writedata[EPPC_DATA_W-1:0]; // RQ1
                     end else if (idx == EPPC_IDX_STATUS) begin
                        if (avs_writedata[EPPC_STS_TIMEOUT]) begin
                           nxt_st.timeout = 1'b0;
                        end
                     end else if (idx == EPPC_IDX_CONTROL) begin
                        nxt_st.ctrl = avs_writedata[EPPC_CTL_W-1:0]; // RQ16
                     end else if (idx == EPPC_IDX_CONFIG) begin
                        nxt_st.epp_en = avs_writedata[EPPC_CFG_EPP_EN];
                     end
                  end
               end
            end
         end
         EPPC_ANSWER: begin
            nxt_st.state = EPPC_IDLE;
         end
         EPPC_SETUP: begin
            // byte has stood on the pins one cycle before the strobe
            if (st_ff.cyc_addr) begin
               nxt_st.addr_strobe_n = 1'b0; // RQ7 RQ9
            end else begin
               nxt_st.data_strobe_n = 1'b0; // RQ18
            end
            nxt_st.state = EPPC_STROBE;
         end
         EPPC_STROBE: begin
            if (wd_expired) begin
               // abort: strobes drop and the host is released with zero data
               nxt_st.timeout = 1'b1; // RQ2 RQ5
               nxt_st.data_strobe_n = 1'b1;
               nxt_st.addr_strobe_n = 1'b1;
               nxt_st.waitrequest = 1'b0;
               nxt_st.state = EPPC_ANSWER;
            end else if (wait_hi) begin
               nxt_st.data_strobe_n = 1'b1; // RQ4 RQ8 RQ11
               nxt_st.addr_strobe_n = 1'b1;
               nxt_st.waitrequest = 1'b0;
               nxt_st.state = EPPC_ANSWER;
               if (st_ff.cyc_read) begin
                  if (st_ff.cyc_addr) begin
                     nxt_st.epp_addr = pd_sync;
                  end else begin
                     nxt_st.epp_data = pd_sync;
                  end
                  if (st_ff.cyc_host_rd) begin
                     nxt_st.readdata[EPPC_DATA_W-1:0] = pd_sync;
                  end
               end else if (st_ff.cyc_addr) begin
                  nxt_st.epp_addr = st_ff.pd_out; // RQ17
               end else begin
                  nxt_st.epp_data = st_ff.pd_out;
               end
            end
         end
      endcase
      // pin levels from control and cycle state, the interrupt output from its synchroniser
      nxt_st.dir_out = nxt_st.ctrl[EPPC_CTL_DIR] ||
                       (nxt_st.cyc_read && (nxt_st.state == EPPC_SETUP ||
                                            nxt_st.state == EPPC_STROBE)); // RQ15
      nxt_st.pd_oe = !nxt_st.dir_out; // RQ9
      // an active spp strobe forces the write line asserted
      nxt_st.write_n = nxt_st.dir_out && !nxt_st.ctrl[EPPC_CTL_STROBE]; // RQ16 RQ12
      nxt_st.strobe_n = !nxt_st.ctrl[EPPC_CTL_STROBE]; // RQ1
      nxt_st.autofd_n = !nxt_st.ctrl[EPPC_CTL_AUTOFD];
      nxt_st.init_n = nxt_st.ctrl[EPPC_CTL_INIT]; // RQ12
      nxt_st.select_in_n = !nxt_st.ctrl[EPPC_CTL_SELIN];
      nxt_st.intr_out = sy_out[EPPC_SY_INTR]; // RQ14
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         st_ff <= '0;
         st_ff.state <= EPPC_IDLE;
         st_ff.waitrequest <= 1'b1;
         st_ff.ctrl <= EPPC_CTL_RST;
         st_ff.epp_addr <= EPPC_BYTE_RST;
         st_ff.epp_data <= EPPC_BYTE_RST;
         st_ff.pd_oe <= 1'b1;
         st_ff.write_n <= 1'b1;
         st_ff.data_strobe_n <= 1'b1;
         st_ff.addr_strobe_n <= 1'b1;
         st_ff.strobe_n <= 1'b1;
         st_ff.autofd_n <= 1'b1;
         st_ff.select_in_n <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign avs_readdata = st_ff.readdata;
   assign avs_waitrequest = st_ff.waitrequest;
   assign peripheral_data_pins_out = st_ff.pd_out;
   assign peripheral_data_pins_oe = st_ff.pd_oe;
   assign write_n = st_ff.write_n;
   assign data_strobe_n = st_ff.data_strobe_n;
   assign address_strobe_alt_n = st_ff.addr_strobe_n;
   assign direction_output = st_ff.dir_out;
   assign strobe_n = st_ff.strobe_n;
   assign autofeed_n = st_ff.autofd_n;
   assign periph_reset_n = st_ff.init_n;
   assign select_in_n = st_ff.select_in_n;
   assign intr_out = st_ff.intr_out;

endmodule // eppc_port

// >>> hdl/eppc_sync.sv
// two-flop synchroniser for a group of pin levels
module eppc_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // levels
   input wire logic [W-1:0] d_async,
   output logic [W-1:0] q_sync
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } eppc_sync_st_t;

   eppc_sync_st_t st_ff;
   eppc_sync_st_t nxt_st;

   // first stage feeds the second stage only
   always_comb begin
      nxt_st.s1 = d_async;
      nxt_st.s2 = st_ff.s1;
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign q_sync = st_ff.s2;

endmodule // eppc_sync

// >>> hdl/eppc_wdog.sv
// cycle watchdog: flags a run that lasts past its limit
module eppc_wdog #(
   parameter int LIMIT = eppc_pkg::EPPC_WDOG_CYC,
   parameter int CW = eppc_pkg::EPPC_WDOG_W
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // control
   input wire logic run,
   output logic expired
);
   import eppc_pkg::*;

   localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic expired;
   } eppc_wdog_st_t;

   eppc_wdog_st_t st_ff;
   eppc_wdog_st_t nxt_st;

   // count clock cycles while a cycle runs, restart from zero when it ends
   always_comb begin
      nxt_st = st_ff;
      nxt_st.expired = 1'b0;
      if (!run) begin
         nxt_st.cnt = '0;
      end else if (st_ff.cnt == LAST) begin
         nxt_st.expired = 1'b1; // RQ19
      end else begin
         nxt_st.cnt = st_ff.cnt + 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign expired = st_ff.expired;

endmodule // eppc_wdog
